// *** rtl/parallel_absolute_position_port.sv ***
// Parallel absolute multiturn position port with register access
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`default_nettype none

// Contract
// - Drive outputs only while enable pin low
// - Freeze high holds presented word constant
// - Count sense picks increasing rotation direction
// - Presented word refreshes faster than 200 us
// - Within-turn part is 13 bits
// - Turn-count part is 16 bits
// - Output word never exceeds 25 bits
module parallel_absolute_position_port #(
	parameter int PRESET_CYCLES  = position_port_pkg::PRESET_CYCLES,
	parameter int REFRESH_CYCLES = position_port_pkg::REFRESH_CYCLES
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Control pins, asynchronous levels
	input  wire logic        output_enable_n,
	input  wire logic        freeze_position,
	input  wire logic        count_sense,
	input  wire logic        preset_to_value,
	// Sensing element, asynchronous
	input  wire logic        sense_step,
	input  wire logic        sense_cw,
	// Parallel position pins
	output logic [24:0]      pos_out,
	output logic             pos_oe,
	// Avalon-MM slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest
);

	localparam int SB = position_port_pkg::STEP_BITS;
	localparam int TB = position_port_pkg::TURN_BITS;
	localparam int WB = position_port_pkg::WORD_BITS;
	localparam int HB = position_port_pkg::HOLD_BITS;
	localparam int RB = position_port_pkg::TIMER_BITS;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Binary to Gray conversion of a position word
	function automatic logic [WB-1:0] to_gray(input logic [WB-1:0] b);
		return b ^ (b >> 1);
	endfunction : to_gray

	// Merge write data into a register under byte enables
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] pins_s;          // Synchronised pin levels
	logic       drive_s;         // Enable pin low, outputs active
	logic       frz_s;           // Freeze level
	logic       sense_s;         // Count sense level
	logic       prs_s;           // Preset request level
	logic       step_s;          // Sensor step level
	logic       cw_s;            // Sensor rotation clockwise

	pin_sync #(.WIDTH(6)) u_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     ({~output_enable_n, freeze_position, count_sense,
			preset_to_value, sense_step, sense_cw}),
		.level   (pins_s)
	);
	// Undriven controls resolve through the board pulls
	assign {drive_s, frz_s, sense_s, prs_s, step_s, cw_s} = pins_s;

	// ----------------------------------------------------------------
	// Live position counter
	// ----------------------------------------------------------------
	logic [WB-1:0] live;         // {turns, steps}
	logic [WB-1:0] next_live;
	logic          step_d;       // Previous step level
	logic          next_step_d;
	logic [HB-1:0] hold;         // Preset hold time so far
	logic [HB-1:0] next_hold;
	logic          preset_done;  // Preset taken for this request
	logic          next_preset_done;
	logic [WB-1:0] preset_value; // Stored value from software
	logic          step_rise;    // One step seen
	logic          count_up;     // Direction of this step
	logic          preset_fire;  // Load the stored value now

	assign step_rise   = step_s & ~step_d;
	assign count_up    = cw_s ^ sense_s;
	assign preset_fire = prs_s & ~preset_done &
		(hold == HB'(PRESET_CYCLES - 1));

	// Counter next state; steps wrap into the turn count
	always_comb begin
		next_step_d      = step_s;
		next_live        = live;
		next_hold        = hold;
		next_preset_done = preset_done;
		if (!prs_s) begin
			// Request released, rearm
			next_hold        = '0;
			next_preset_done = 1'b0;
		end else if (!preset_done) begin
			next_hold = hold + HB'(1);
		end
		if (preset_fire) begin
			next_live        = preset_value;
			next_preset_done = 1'b1;
		end else if (step_rise) begin
			// 13-bit step part carries into 16-bit turn count
			next_live = count_up ? live + WB'(1) : live - WB'(1);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			step_d      <= 1'b0;
			live        <= '0;
			hold        <= '0;
			preset_done <= 1'b0;
		end else begin
			step_d      <= next_step_d;
			live        <= next_live;
			hold        <= next_hold;
			preset_done <= next_preset_done;
		end
	end

	// ----------------------------------------------------------------
	// Presented word and pins
	// ----------------------------------------------------------------
	logic [RB-1:0] timer;        // Refresh interval timer
	logic [RB-1:0] next_timer;
	logic [WB-1:0] word;         // Presented position
	logic [WB-1:0] next_word;
	logic [24:0]   next_pos_out;
	logic          gray_mode;    // Control register bit
	logic          tick;         // Refresh instant

	assign tick = (timer == RB'(REFRESH_CYCLES - 1));

	// Refresh unless frozen
	always_comb begin
		next_timer = tick ? '0 : timer + RB'(1);
		next_word  = word;
		if (tick && !frz_s) begin
			next_word = gray_mode ? to_gray(live) : live;
		end
		// Steps in bits 0..12, turns above, top bits cut
		next_pos_out = drive_s ? word[24:0] : 25'h0;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer   <= '0;
			word    <= '0;
			pos_out <= 25'h0;
			pos_oe  <= 1'b0;
		end else begin
			timer   <= next_timer;
			word    <= next_word;
			pos_out <= next_pos_out;
			pos_oe  <= drive_s;
		end
	end

	// ----------------------------------------------------------------
	// Avalon-MM register slave
	// ----------------------------------------------------------------
	logic        ack;            // Answer cycle
	logic        next_ack;
	logic [31:0] next_readdata;
	logic        next_gray_mode;
	logic [WB-1:0] next_preset_value;
	logic [31:0] status;
	logic [31:0] ctrl_merged;    // Control word after lane merge
	logic [31:0] preset_merged;  // Preset word after lane merge

	// Lane merge kept outside the process so only plain selects follow
	assign ctrl_merged   = merge({31'h0, gray_mode}, writedata,
		byteenable);
	assign preset_merged = merge({3'h0, preset_value}, writedata,
		byteenable);

	assign waitrequest = (read | write) & ~ack;
	assign status = {28'h0, preset_done, sense_s, drive_s, frz_s};

	// One wait state, then answer with registered data
	always_comb begin
		next_ack          = (read | write) & ~ack;
		next_readdata     = readdata;
		next_gray_mode    = gray_mode;
		next_preset_value = preset_value;
		if (read && !ack) begin
			case ({address[3:2], 2'b00})
				position_port_pkg::OFS_CONTROL:
					next_readdata = {31'h0, gray_mode};
				position_port_pkg::OFS_PRESET:
					next_readdata = {3'h0, preset_value};
				position_port_pkg::OFS_LIVE:
					next_readdata = {3'h0, live};
				position_port_pkg::OFS_STATUS:
					next_readdata = status;
				default:
					next_readdata = 32'h0;
			endcase
		end
		if (write && !ack) begin
			case ({address[3:2], 2'b00})
				position_port_pkg::OFS_CONTROL:
					next_gray_mode = ctrl_merged[0];
				position_port_pkg::OFS_PRESET:
					next_preset_value = preset_merged[WB-1:0];
				default: begin
					// Read-only or unmapped: ignored
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ack          <= 1'b0;
			readdata     <= 32'h0;
			gray_mode    <= position_port_pkg::CONTROL_RESET;
			preset_value <= position_port_pkg::PRESET_RESET;
		end else begin
			ack          <= next_ack;
			readdata     <= next_readdata;
			gray_mode    <= next_gray_mode;
			preset_value <= next_preset_value;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_pins_off_zero: assert property (!drive_s |=> pos_out == 25'h0 && !pos_oe)
		else $error("Outputs not released while disabled");
	a_pins_show_word: assert property (drive_s |=> pos_oe && pos_out == $past(word[24:0]))
		else $error("Outputs do not present the word");
	a_freeze_holds: assert property (frz_s |=> $stable(word))
		else $error("Word changed while frozen");
	a_refresh_loads: assert property (tick && !frz_s && !gray_mode |=> word == $past(live))
		else $error("Word did not follow live position");
	a_refresh_gray: assert property (tick && !frz_s && gray_mode |=>
		word == $past(to_gray(live)))
		else $error("Word did not follow live position in Gray code");
	a_refresh_bound: assert property (!rst && timer != RB'(REFRESH_CYCLES - 1) |=> timer == $past(timer) + RB'(1))
		else $error("Refresh timer skipped");
	// The timer itself is the interval counter: wrap to zero on each tick
	// and never pass the last count, so ticks are at most one period apart
	a_refresh_wrap: assert property (tick |=> timer == '0)
		else $error("Refresh timer did not restart");
	a_timer_ceiling: assert property (timer <= RB'(REFRESH_CYCLES - 1))
		else $error("Refresh interval too long");
	a_count_dir: assert property (step_rise && !preset_fire && (cw_s ^ sense_s) |=> live == $past(live) + WB'(1))
		else $error("Position did not increase");
	a_count_down: assert property (step_rise && !preset_fire && !(cw_s ^ sense_s) |=> live == $past(live) - WB'(1))
		else $error("Position did not decrease");
	a_preset_load: assert property (preset_fire |=> live == $past(preset_value) && preset_done)
		else $error("Preset value not loaded");
	a_preset_rearm: assert property (!prs_s |=> hold == '0 && !preset_done)
		else $error("Preset hold not cleared");
	a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("Bus answer late");

endmodule : parallel_absolute_position_port

`default_nettype wire

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for asynchronous pin levels
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Pins in, synchronised levels out
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level
);

	logic [WIDTH-1:0] stage1;   // Only read by the second stage
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_level;

	// Shift chain
	always_comb begin
		next_stage1 = pin;
		next_level  = stage1;
	end

	// Registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stage1 <= '0;
			level  <= '0;
		end else begin
			stage1 <= next_stage1;
			level  <= next_level;
		end
	end

endmodule : pin_sync

`default_nettype wire

// *** shared/position_port_pkg.sv ***
// Constants shared by the parallel absolute position port design
`default_nettype none

package position_port_pkg;

	// ----------------------------------------------------------------
	// Position word layout
	// ----------------------------------------------------------------
	localparam int STEP_BITS   = 13;                      // Within one turn
	localparam int TURN_BITS   = 16;                      // Turn count
	localparam int WORD_BITS   = STEP_BITS + TURN_BITS;   // Internal word
	localparam int OUT_BITS    = 25;                      // Parallel pins
	localparam int STEP_LSB    = 0;                       // Steps from bit 0
	localparam int TURN_LSB    = STEP_BITS;               // Turns above

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 8;     // 125 MHz
	localparam int PRESET_TIME_MS  = 100;   // Least preset hold
	localparam int REFRESH_TIME_US = 200;   // Refresh bound, exclusive
	// Least time rounds up
	localparam int PRESET_CYCLES =
		(PRESET_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Strictly shorter than the bound
	localparam int REFRESH_CYCLES =
		(REFRESH_TIME_US * 1000) / CLK_PERIOD_NS - 1;
	localparam int HOLD_BITS  = 24;         // Preset hold counter width
	localparam int TIMER_BITS = 15;         // Refresh timer width

	// ----------------------------------------------------------------
	// Register map (byte offsets)
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_CONTROL = 4'h0;   // Code select
	localparam logic [3:0] OFS_PRESET  = 4'h4;   // Stored preset value
	localparam logic [3:0] OFS_LIVE    = 4'h8;   // Live position, RO
	localparam logic [3:0] OFS_STATUS  = 4'hc;   // Pin state, RO
	localparam int CTRL_GRAY_BIT   = 0;          // 1: Gray coded output
	localparam int STAT_FROZEN_BIT = 0;          // Freeze input high
	localparam int STAT_DRIVE_BIT  = 1;          // Outputs driven
	localparam int STAT_SENSE_BIT  = 2;          // Count sense input
	localparam int STAT_PRESET_BIT = 3;          // Preset taken, held
	localparam logic        CONTROL_RESET = 1'h0;
	localparam logic [28:0] PRESET_RESET  = 29'h0;

endpackage : position_port_pkg

`default_nettype wire

// *** verif/position_sampler.sv ***
// Far-side controller model that samples the parallel position word
`default_nettype none

module position_sampler (
	// Clock
	input  wire logic        ref_clk,
	// Parallel position pins
	input  wire logic [24:0] pos_out,
	input  wire logic        pos_oe,
	// Last word taken while driven
	output logic      [24:0] word
);
	timeunit 1ns;
	timeprecision 1ps;

	// Take the word only while the port drives it
	initial word = 25'h0;
	always @(posedge ref_clk) begin
		if (pos_oe === 1'b1) begin
			word <= pos_out;
		end
	end
endmodule : position_sampler

`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the parallel absolute position port
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        ref_clk, rst, output_enable_n, freeze_position;
	logic        count_sense, preset_to_value, sense_step, sense_cw;
	logic [24:0] pos_out, word;
	logic        pos_oe, read, write, waitrequest;
	logic [3:0]  address, byteenable;
	logic [31:0] writedata, readdata, q;
	int          num_errors, compares, cycles;

	parallel_absolute_position_port #(
		.PRESET_CYCLES (20),
		.REFRESH_CYCLES(16)
	) parallel_absolute_position_port_i (
		.ref_clk, .rst, .output_enable_n, .freeze_position, .count_sense,
		.preset_to_value, .sense_step, .sense_cw, .pos_out, .pos_oe,
		.address, .read, .write, .byteenable, .writedata, .readdata,
		.waitrequest
	);
	position_sampler position_sampler_i (.ref_clk, .pos_out, .pos_oe,
		.word);

	// ------------------------------------------------------------
	// Clock and hang guard
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			final_report();
		end
	end

	task automatic chk(input string n, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Avalon access held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a,
			input logic [31:0] d);
		@(posedge ref_clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		// Only the bench timeout ends a wait that never answers
		do begin
			@(posedge ref_clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	// One sensor step, clockwise when cw is high
	task automatic step(input logic cw);
		@(posedge ref_clk);
		sense_cw <= cw;
		sense_step <= 1'b1;
		repeat (4) @(posedge ref_clk);
		sense_step <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask : step

	// Preset pin held high for n cycles
	task automatic preset(input int n);
		@(posedge ref_clk);
		preset_to_value <= 1'b1;
		repeat (n) @(posedge ref_clk);
		preset_to_value <= 1'b0;
		repeat (6) @(posedge ref_clk);
	endtask : preset

	task automatic live(input logic [31:0] e);
		bus(1'b0, 4'h8, 32'h0);
		chk("live", q, e);
	endtask : live

	task automatic final_report();
		$display("checks %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{output_enable_n, freeze_position, count_sense} = 3'h0;
		{preset_to_value, sense_step, sense_cw, read, write} = 5'h0;
		{address, byteenable, writedata} = 40'h0;
		{num_errors, compares, cycles} = '0;
		rst = 1'b1;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		byteenable <= 4'hf;
		// Reset state
		chk("pos_oe", pos_oe, 1'b0);
		bus(1'b0, 4'h0, 32'h0);
		chk("control", q, 32'h0);
		bus(1'b0, 4'h4, 32'h0);
		chk("preset", q, 32'h0);
		live(32'h0);
		$display("test reset done");
		// Clockwise counts up, counter-clockwise down
		repeat (3) step(1'b1);
		step(1'b0);
		live(32'h2);
		repeat (40) @(posedge ref_clk);
		chk("pos_out", pos_out, 25'h2);
		chk("pos_oe", pos_oe, 1'b1);
		chk("sampled", word, 25'h2);
		// Reversed sense
		count_sense <= 1'b1;
		step(1'b1);
		step(1'b0);
		step(1'b0);
		live(32'h3);
		$display("test direction done");
		// Frozen word stays while live moves on
		freeze_position <= 1'b1;
		repeat (40) @(posedge ref_clk);
		// Frozen, driving, sense high, no preset taken
		bus(1'b0, 4'hc, 32'h0);
		chk("status", q, 32'h7);
		step(1'b0);
		repeat (40) @(posedge ref_clk);
		chk("frozen", pos_out, 25'h3);
		live(32'h4);
		freeze_position <= 1'b0;
		repeat (40) @(posedge ref_clk);
		chk("thawed", pos_out, 25'h4);
		// Gray output of live position 4 is 6
		bus(1'b1, 4'h0, 32'h1);
		bus(1'b0, 4'h0, 32'h0);
		chk("control", q, 32'h1);
		repeat (40) @(posedge ref_clk);
		chk("gray", pos_out, 25'h6);
		bus(1'b1, 4'h0, 32'h0);
		$display("test freeze done");
		// Short preset ignored, full preset loads, full wrap
		bus(1'b1, 4'h4, 32'h1fffffff);
		preset(10);
		live(32'h4);
		preset(25);
		live(32'h1fffffff);
		count_sense <= 1'b0;
		step(1'b1);
		live(32'h0);
		// Step carry into the turn count
		bus(1'b1, 4'h4, 32'h1fff);
		preset(25);
		step(1'b1);
		live(32'h2000);
		repeat (40) @(posedge ref_clk);
		chk("carry", pos_out, 25'h2000);
		$display("test preset done");
		// Outputs released
		output_enable_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk("oe_off", pos_oe, 1'b0);
		chk("out_off", pos_out, 25'h0);
		$display("test enable done");
		final_report();
	end
endmodule : tb

`default_nettype wire
